// >>> rtl/msc_pin_meas.sv
`timescale 1ns/1ps
// Measures duty and edge rate of the synchronised speed pin
module msc_pin_meas
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pin_sync,
  output logic [msc_pkg::DUTY_W-1:0] pwm_duty,
  output logic [msc_pkg::CNT_W-1:0] freq_count
);
  import msc_pkg::*;

  typedef struct packed
  {
    logic prev;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] high;
    logic [CNT_W-1:0] gate;
    logic [CNT_W-1:0] edges;
    logic [DUTY_W-1:0] duty;
    logic [CNT_W-1:0] freq;
  } msc_meas_t;

  msc_meas_t st;
  msc_meas_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.prev = pin_sync;
    next_st.period = st.period + CNT_W'(1);
    if (pin_sync)
      next_st.high = st.high + CNT_W'(1);
    // Rising edge closes one period; a stuck pin keeps the last duty
    if (pin_sync && !st.prev)
    begin
      next_st.duty = lin_map(st.high, CNT_W'(CNT_RST), st.period);
      next_st.period = CNT_W'(1);
      next_st.high = CNT_W'(1);
      next_st.edges = st.edges + CNT_W'(1);
    end
    next_st.gate = st.gate + CNT_W'(1);
    if (st.gate == CNT_W'(FREQ_GATE_CYC - 1))
    begin
      next_st.gate = '0;
      next_st.freq = st.edges;
      next_st.edges = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign pwm_duty = st.duty;
  assign freq_count = st.freq;
endmodule

// >>> rtl/msc_pkg.sv
package msc_pkg;

  // ----------------------------------------
  // Widths and encodings
  // ----------------------------------------
  localparam int ADC_W = 12;
  localparam int DUTY_W = 16;
  localparam int CNT_W = 24;

  typedef enum logic [1:0]
  {
    MSC_SRC_ANALOG = 2'b00,
    MSC_SRC_PWM = 2'b01,
    MSC_SRC_I2C = 2'b10,
    MSC_SRC_FREQ = 2'b11
  } msc_src_t;

  localparam logic LOW_POWER_SLEEP = 1'b1;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 16'hffff;
  localparam logic [DUTY_W-1:0] DUTY_ZERO = 16'h0000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int FREQ_GATE_MS = 100;
  localparam int FREQ_GATE_CYC = CLK_HZ / 1000 * FREQ_GATE_MS;
  localparam int CNT_RST = 0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed
  {
    msc_src_t speed_source;
    logic low_power_device_config;
    logic [ADC_W-1:0] standby_entry_level;
    logic [ADC_W-1:0] standby_exit_level;
    logic [ADC_W-1:0] analog_full_scale_level;
    logic [CNT_W-1:0] freq_entry_count;
    logic [CNT_W-1:0] freq_exit_count;
    logic [CNT_W-1:0] freq_full_count;
    logic [DUTY_W-1:0] top_speed_limit;
  } msc_cfg_t;

  typedef struct packed
  {
    logic [DUTY_W-1:0] duty_cmd;
    logic [DUTY_W-1:0] speed_ref;
    logic motor_stop;
    logic source_refused;
  } msc_out_t;

  // Linear map of x in [lo,hi] onto 0..full; clamped at both ends
  function automatic logic [DUTY_W-1:0] lin_map(
    input logic [CNT_W-1:0] x,
    input logic [CNT_W-1:0] lo,
    input logic [CNT_W-1:0] hi
  );
    logic [CNT_W+DUTY_W-1:0] num;
    logic [CNT_W-1:0] span;
    num = '0;
    span = hi - lo;
    if (x <= lo || hi <= lo)
      lin_map = DUTY_ZERO;
    else if (x >= hi)
      lin_map = DUTY_FULL;
    else
    begin
      num = (CNT_W+DUTY_W)'(x - lo) * (CNT_W+DUTY_W)'(DUTY_FULL);
      lin_map = DUTY_W'(num / (CNT_W+DUTY_W)'(span));
    end
  endfunction

endpackage

// >>> rtl/msc_speed_select.sv
`timescale 1ns/1ps
// Notes on behaviour
// - One of four sources sets the command
// - Select 00 uses the analog pin level
// - Pin sources only in standby-type configuration
// - Setpoint source works in both configurations
// - Zero top limit forces reference zero
// - Analog below entry level gives zero
// - Analog linear from exit to full scale
// - Analog above full scale saturates full
// - Select 01 maps pin duty linearly
// - Select 10 uses written setpoint
// - Select 11 maps pin frequency linearly
module msc_speed_select
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire msc_pkg::msc_cfg_t cfg,
  input wire logic speed_pin,
  input wire logic [msc_pkg::ADC_W-1:0] speed_level,
  input wire logic [msc_pkg::DUTY_W-1:0] setpoint,
  output msc_pkg::msc_out_t status
);
  import msc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    logic pin_meta;
    logic pin_sync;
    logic [ADC_W-1:0] lvl_meta;
    logic [ADC_W-1:0] lvl_sync;
    logic ana_run;
    logic frq_run;
    msc_out_t out;
  } msc_state_t;

  msc_state_t st;
  msc_state_t next_st;
  logic [DUTY_W-1:0] pwm_duty;
  logic [CNT_W-1:0] freq_count;

  msc_pin_meas u_meas
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_sync(st.pin_sync),
    .pwm_duty(pwm_duty),
    .freq_count(freq_count)
  );

  // ----------------------------------------
  // Command selection
  // ----------------------------------------
  always_comb
  begin
    logic [DUTY_W-1:0] cmd;
    logic pin_src;
    cmd = DUTY_ZERO;
    pin_src = (cfg.speed_source != MSC_SRC_I2C);
    next_st = st;
    // Two stages before any logic sees the pin or sampled level
    // Level word is quasi-static; a code caught mid-change lasts one cycle
    next_st.pin_meta = speed_pin;
    next_st.pin_sync = st.pin_meta;
    next_st.lvl_meta = speed_level;
    next_st.lvl_sync = st.lvl_meta;
    // Hysteresis between entry and exit levels keeps the last state
    if (st.lvl_sync <= cfg.standby_entry_level)
      next_st.ana_run = 1'b0;
    else if (st.lvl_sync >= cfg.standby_exit_level)
      next_st.ana_run = 1'b1;
    if (freq_count <= cfg.freq_entry_count)
      next_st.frq_run = 1'b0;
    else if (freq_count >= cfg.freq_exit_count)
      next_st.frq_run = 1'b1;
    unique case (cfg.speed_source)
      MSC_SRC_ANALOG:
      begin
        if (!st.ana_run)
          cmd = DUTY_ZERO;
        else if (st.lvl_sync > cfg.analog_full_scale_level)
          cmd = DUTY_FULL;
        else
          cmd = lin_map(CNT_W'(st.lvl_sync), CNT_W'(cfg.standby_exit_level),
                        CNT_W'(cfg.analog_full_scale_level));
      end
      MSC_SRC_PWM:
        cmd = pwm_duty;
      MSC_SRC_I2C:
        cmd = setpoint;
      MSC_SRC_FREQ:
        cmd = st.frq_run ? lin_map(freq_count, cfg.freq_exit_count,
                                   cfg.freq_full_count) : DUTY_ZERO;
    endcase
    // Pin sources refused in sleep-type configuration; command held at zero
    if (pin_src && cfg.low_power_device_config == LOW_POWER_SLEEP)
      cmd = DUTY_ZERO;
    next_st.out.source_refused = pin_src && cfg.low_power_device_config == LOW_POWER_SLEEP;
    next_st.out.duty_cmd = cmd;
    // Reference scales command by top limit; zero limit stops the motor
    if (cfg.top_speed_limit == DUTY_ZERO)
      next_st.out.speed_ref = DUTY_ZERO;
    else
      next_st.out.speed_ref = DUTY_W'((32'(cmd) * 32'(cfg.top_speed_limit)) >> DUTY_W);
    next_st.out.motor_stop = (next_st.out.speed_ref == DUTY_ZERO);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.out.motor_stop <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign status = st.out;
endmodule

// >>> sim/msc_pin_src.sv
`timescale 1ns/1ps
// Speed pin source: 100-cycle period, idles low when off
module msc_pin_src (
  input wire logic ref_clk,
  input wire logic en,
  input wire logic [7:0] hi,
  output logic pin
);
  logic [7:0] cnt = 8'h00;
  always_ff @(posedge ref_clk)
  begin
    cnt <= (cnt == 8'h63) ? 8'h00 : cnt + 8'h01;
    pin <= en && (cnt < hi);
  end
endmodule

// >>> sim/msc_speed_select_checker.sv
`timescale 1ns/1ps
module msc_speed_select_checker
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire msc_pkg::msc_cfg_t cfg,
  input wire logic [msc_pkg::ADC_W-1:0] speed_level,
  input wire logic [msc_pkg::DUTY_W-1:0] setpoint,
  input wire msc_pkg::msc_out_t status
);
  import msc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ana_low;
    (cfg.speed_source == MSC_SRC_ANALOG && !cfg.low_power_device_config
      && speed_level <= cfg.standby_entry_level) [*5];
  endsequence
  sequence s_ana_high;
    (cfg.speed_source == MSC_SRC_ANALOG && !cfg.low_power_device_config
      && speed_level > cfg.analog_full_scale_level) [*5];
  endsequence
  sequence s_i2c;
    cfg.speed_source == MSC_SRC_I2C;
  endsequence
  a_i2c_follow: assert property (s_i2c |=> status.duty_cmd == $past(setpoint))
    else $error("duty does not follow setpoint");
  a_i2c_ref: assert property (s_i2c |=> status.speed_ref ==
    16'((32'($past(setpoint)) * 32'($past(cfg.top_speed_limit))) >> 16))
    else $error("reference not scaled by limit");
  a_i2c_any_mode: assert property (s_i2c |=> !status.source_refused)
    else $error("setpoint source refused");
  a_pin_refused: assert property (cfg.low_power_device_config && cfg.speed_source != MSC_SRC_I2C
    |=> status.source_refused && status.duty_cmd == DUTY_ZERO)
    else $error("pin source not refused");
  a_zero_limit: assert property (cfg.top_speed_limit == 16'h0000
    |=> status.speed_ref == DUTY_ZERO)
    else $error("reference not zero");
  a_zero_stop: assert property (cfg.top_speed_limit == 16'h0000 |=> status.motor_stop)
    else $error("motor not stopped");
  a_ana_low: assert property (s_ana_low |=> status.duty_cmd == DUTY_ZERO)
    else $error("low level not zero");
  a_ana_full: assert property (s_ana_high |=> status.duty_cmd == DUTY_FULL)
    else $error("high level not saturated");
endmodule
bind msc_speed_select msc_speed_select_checker i_chk (.ref_clk, .rst_n, .cfg, .speed_level,
  .setpoint, .status);

// >>> sim/msc_speed_select_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module msc_speed_select_tb;
  import msc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_en = 1'b0;
  logic [7:0] hi = 8'h19;
  logic speed_pin;
  logic [ADC_W-1:0] speed_level = 12'h000;
  logic [ADC_W-1:0] lv [4] = '{12'h000, 12'h100, 12'he00, 12'hfff};
  logic [DUTY_W-1:0] setpoint = 16'h0000;
  logic [DUTY_W-1:0] d_lo;
  logic [31:0] rs = 32'h2c;
  msc_cfg_t cfg = '0;
  msc_out_t status;
  int n_fail = 0;
  int comparisons = 0;
  msc_speed_select i_dut (.ref_clk, .rst_n, .cfg, .speed_pin, .speed_level, .setpoint, .status);
  msc_pin_src i_src (.ref_clk, .en(pin_en), .hi, .pin(speed_pin));
  initial forever #25 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  function automatic logic [DUTY_W-1:0] lin(input logic [31:0] x, a, b);
    if (x <= a)
      return DUTY_ZERO;
    if (x >= b)
      return DUTY_FULL;
    return DUTY_W'((x - a) * 32'hffff / (b - a));
  endfunction
  function automatic logic [DUTY_W-1:0] rf(input logic [31:0] c, l);
    return DUTY_W'((c * l) >> 16);
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(8);
    rst_n = 1'b1;
    // Settling wait kept short; the block itself needs none
    cyc(1);
    cfg.speed_source = MSC_SRC_I2C;
    for (int i = 0; i < 24; i++)
    begin
      rs = xs(rs);
      setpoint = rs[15:0];
      cfg.top_speed_limit = i[0] ? 16'h0000 : rs[31:16];
      cfg.low_power_device_config = rs[7];
      cyc(2);
      `CHK("duty", setpoint, status.duty_cmd)
      `CHK("ref", rf(setpoint, cfg.top_speed_limit), status.speed_ref)
      `CHK("stop", 1'(rf(setpoint, cfg.top_speed_limit) == DUTY_ZERO), status.motor_stop)
      `CHK("refused", 1'b0, status.source_refused)
    end
    $display("setpoint test done");
    // Entry equal to exit removes the hysteresis band
    cfg = '0;
    cfg.standby_entry_level = 12'h100;
    cfg.standby_exit_level = 12'h100;
    cfg.analog_full_scale_level = 12'he00;
    cfg.top_speed_limit = 16'hffff;
    for (int i = 0; i < 16; i++)
    begin
      rs = xs(rs);
      speed_level = (i < 4) ? lv[i] : rs[11:0];
      cyc(8);
      `CHK("analog", lin(speed_level, 12'h100, 12'he00), status.duty_cmd)
    end
    $display("analog test done");
    cfg.low_power_device_config = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      cfg.speed_source = msc_src_t'(i);
      cyc(2);
      `CHK("refused", 1'(i != 2), status.source_refused)
      `CHK("refused duty", (i == 2) ? setpoint : DUTY_ZERO, status.duty_cmd)
    end
    $display("refusal test done");
    cfg.low_power_device_config = 1'b0;
    cfg.speed_source = MSC_SRC_PWM;
    pin_en = 1'b1;
    cyc(400);
    `CHK("pwm low", lin(32'(hi), 32'h0, 32'h64), status.duty_cmd)
    d_lo = status.duty_cmd;
    hi = 8'h4b;
    cyc(400);
    `CHK("pwm", 1'b1, status.duty_cmd > d_lo)
    `CHK("pwm high", lin(32'(hi), 32'h0, 32'h64), status.duty_cmd)
    $display("pwm test done");
    // No rate gate has closed yet, so the rate sits at or below entry
    cfg.speed_source = MSC_SRC_FREQ;
    cyc(2);
    `CHK("freq", DUTY_ZERO, status.duty_cmd)
    $display("frequency test done");
    close_out();
  end
  initial
  begin
    cyc(4000);
    n_fail++;
    close_out();
  end
endmodule
